// File: rtl/ifq_front_end.sv
// Purpose: fetch, instruction queue, dispatch and retire timing
// Assumes: caches answer in the cycle of a request; classes decoded
// Notes:   integer ops finish one cycle after dispatch
//
// Overview of operation
// RL1: hold fetch while cache reloads a line
// RL2: L1 hit fills queue next cycle
// RL3: cache hits allowed under a pending miss; here fetch waits until the miss is served
// RL4: critical double word cached and forwarded together
// RL5: fetch count equals last-cycle queue vacancies, capped at four
// RL6: dispatch from two lowest slots, lowest entries
// RL7: dispatch limited by last-cycle retire queue vacancies
// RL8: fold taken non-link branches, no entry
// RL9: target cache hit delivers two next cycle
// RL10: floating pipe has three stages, one/cycle
// RL11: retire strictly in program order
// RL12: at most two retire per cycle
// RL13: retiring frees entry within its cycle
// RL14: memory beat of two goes to cache and queue
// RL15: level-two hit returns after five cycles
// RL16: six-entry fifo retire queue
// RL17: second slot never dispatches before first
// RL18: reset empties queues, cancels fetch
`default_nettype none
module ifq_front_end
  import ifq_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // level-one cache
  output logic                       l1_req,
  output logic [ADDR_W-1:0]          l1_addr,
  output logic [2:0]                 l1_count,
  input  wire logic                  l1_busy,
  input  wire logic                  l1_hit,
  input  wire ifq_pkg::ifq_insn_type l1_data [ifq_pkg::FETCH_MAX],
  // branch target cache
  input  wire logic                  btc_hit,
  input  wire ifq_pkg::ifq_insn_type btc_data [ifq_pkg::BTC_INSNS],
  // level-two cache
  output logic                       l2_req,
  input  wire logic                  l2_hit,
  input  wire ifq_pkg::ifq_insn_type l2_data [ifq_pkg::BEAT_INSNS],
  // system bus beat
  output logic                       mem_req,
  input  wire logic                  mem_beat,
  input  wire ifq_pkg::ifq_insn_type mem_data [ifq_pkg::BEAT_INSNS],
  output logic                       fill_write,
  output ifq_pkg::ifq_insn_type      fill_data [ifq_pkg::BEAT_INSNS],
  // branch resolution from decode
  input  wire logic                  br_taken,
  input  wire logic [ADDR_W-1:0]     br_target,
  input  wire logic                  br_updates_link,
  // classification of the two lowest slots
  input  wire ifq_pkg::ifq_class_type slot_class [ifq_pkg::DISP_MAX],
  // dispatch and retire view
  output logic [1:0]                 disp_count,
  output ifq_pkg::ifq_insn_type      fetch_slot_first,
  output ifq_pkg::ifq_insn_type      fetch_slot_second,
  output logic [1:0]                 retire_count,
  output logic [IQ_CNT_W-1:0]        iq_level
);
  import ifq_pkg::*;

  ifq_retire_if rq ();

  ifq_insn_type  iq_reg [IQ_DEPTH];
  logic [IQ_CNT_W-1:0] iq_cnt_reg;
  logic [IQ_CNT_W-1:0] iq_vac_reg;
  ifq_state_type state_reg;
  logic [ADDR_W-1:0]   pc_reg;
  logic [L2_CNT_W-1:0] l2_cnt_reg;
  logic                fold_reg;
  logic                int_done_reg [DISP_MAX];
  logic [RQ_IDX_W-1:0] int_idx_reg  [DISP_MAX];
  logic                fp_issue;
  logic [RQ_IDX_W-1:0] fp_issue_idx;
  logic                fp_done;
  logic [RQ_IDX_W-1:0] fp_done_idx;

  // fetch size is last-cycle vacancy capped at four; zero if full
  wire [2:0] want = (iq_vac_reg > IQ_CNT_W'(FETCH_MAX)) ?
                    3'(FETCH_MAX) : 3'(iq_vac_reg);         // see RL5
  wire idle = (state_reg == IFQ_ST_IDLE);

  // a folded branch redirects; target cache gives two at once
  wire fold_now = br_taken && !br_updates_link &&
                  (iq_cnt_reg != IQ_CNT_ZERO);              // see RL8
  wire btc_take = fold_reg && btc_hit;                      // see RL9

  // cache arbitration: no level-one request while a reload is running
  assign l1_req   = idle && !l1_busy && (want != 3'h0) &&
                    !fold_reg && !fold_now;                 // see RL1
  assign l1_addr  = pc_reg;
  assign l1_count = want;
  wire l1_take    = l1_req && l1_hit;                       // see RL2
  wire l1_miss    = l1_req && !l1_hit && !btc_take;
  assign l2_req   = (state_reg == IFQ_ST_L2) &&
                    (l2_cnt_reg == L2_CNT_W'(0));
  assign mem_req  = (state_reg == IFQ_ST_MEM);

  // critical double word goes to cache and queue in one cycle
  wire beat_take  = mem_req && mem_beat;                    // see RL14
  wire l2_take    = l2_req && l2_hit;                       // see RL15
  assign fill_write = beat_take;                            // see RL4
  assign fill_data  = mem_data;

  // dispatch: slot 0 first, slot 1 only with slot 0
  wire s0_ok = (iq_cnt_reg != IQ_CNT_ZERO) &&
               (slot_class[0] != IFQ_CL_BRANCH_FOLD) &&
               (rq.vacancy != RQ_IDX_W'(0));                // see RL7
  // one float unit only: a second float op waits for the next cycle
  wire s1_ok = s0_ok && (iq_cnt_reg > IQ_CNT_W'(1)) &&
               (slot_class[1] != IFQ_CL_BRANCH_FOLD) &&
               !(slot_class[0] == IFQ_CL_FP &&
                 slot_class[1] == IFQ_CL_FP) &&
               (rq.vacancy > RQ_IDX_W'(1));                 // see RL17
  wire [1:0] d_n = {1'b0, s0_ok} + {1'b0, s1_ok};
  assign disp_count     = d_n;
  assign rq.alloc_count = d_n;                              // see RL6
  assign rq.flush       = 1'b0;

  // number of words arriving this cycle and their source
  wire [2:0] in_n = fold_now ? 3'h0 :
                    btc_take ? 3'(BTC_INSNS) :
                    l1_take ? want :
                    (l2_take || beat_take) ? 3'(BEAT_INSNS) : 3'h0;
  // a fold drops the branch and the wrong-path words queued behind it
  wire [IQ_CNT_W-1:0] rem_n = fold_now ? iq_cnt_reg :
                              IQ_CNT_W'(d_n);               // see RL8
  wire [IQ_CNT_W-1:0] base  = iq_cnt_reg - rem_n;

  function automatic ifq_insn_type pick(input int k);
    if (btc_take)     return btc_data[k % BTC_INSNS];
    else if (l1_take) return l1_data[k % FETCH_MAX];
    else if (l2_take) return l2_data[k % BEAT_INSNS];
    else              return mem_data[k % BEAT_INSNS];
  endfunction

  // shift out dispatched words, append fetched ones behind
  genvar g;
  generate
    for (g = 0; g < IQ_DEPTH; g++) begin : g_iq
      wire [IQ_CNT_W-1:0] src = IQ_CNT_W'(g) + rem_n;
      wire in_slot = (IQ_CNT_W'(g) >= base) &&
                     (IQ_CNT_W'(g) < base + IQ_CNT_W'(in_n));
      always_ff @(posedge clk) begin
        if (in_slot) begin
          iq_reg[g] <= pick(g - int'(base));
        end else if (src < IQ_CNT_W'(IQ_DEPTH)) begin
          iq_reg[g] <= iq_reg[src];
        end
      end
    end
  endgenerate

  // queue level and last-cycle vacancy; reset empties the queue
  always_ff @(posedge clk) begin
    if (reset) begin
      iq_cnt_reg <= IQ_CNT_ZERO;                            // see RL18
      iq_vac_reg <= IQ_CNT_W'(IQ_DEPTH);
    end else begin
      iq_cnt_reg <= base + IQ_CNT_W'(in_n);
      // vacancy left at the end of this cycle sizes the next fetch, so
      // a level-one fetch can never overfill the queue; level-two and memory fills add two words whatever the vacancy
      iq_vac_reg <= IQ_CNT_W'(IQ_DEPTH) - (base + IQ_CNT_W'(in_n));
    end
  end

  // fetch engine: L1 hit or miss to L2, then to system memory
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg  <= IFQ_ST_IDLE;                            // see RL18
      pc_reg     <= RESET_PC;
      l2_cnt_reg <= '0;
      fold_reg   <= 1'b0;
    end else begin
      fold_reg <= fold_now;
      if (fold_now) begin
        pc_reg <= br_target;
      end else if (in_n != 3'h0) begin
        pc_reg <= pc_reg + INSN_BYTES * ADDR_W'(in_n);
      end
      case (state_reg)
        IFQ_ST_IDLE: begin
          if (l1_busy && l1_req) state_reg <= IFQ_ST_WAIT_RELOAD;
          else if (l1_miss) begin
            state_reg  <= IFQ_ST_L2;
            l2_cnt_reg <= L2_CNT_W'(L2_LATENCY - 1);        // see RL15
          end
        end
        IFQ_ST_WAIT_RELOAD: begin
          if (!l1_busy) state_reg <= IFQ_ST_IDLE;           // see RL1
        end
        IFQ_ST_L2: begin
          if (l2_cnt_reg != L2_CNT_W'(0)) begin
            l2_cnt_reg <= l2_cnt_reg - L2_CNT_W'(1);
          end else if (l2_hit) begin
            state_reg <= IFQ_ST_IDLE;
          end else begin
            state_reg <= IFQ_ST_MEM;
          end
        end
        IFQ_ST_MEM: begin
          if (mem_beat) state_reg <= IFQ_ST_IDLE;           // see RL3
        end
        default: state_reg <= IFQ_ST_IDLE;
      endcase
    end
  end

  // integer ops finish next cycle; float ops go down the pipe
  assign fp_issue     = (s0_ok && slot_class[0] == IFQ_CL_FP) ||
                        (s1_ok && slot_class[1] == IFQ_CL_FP);
  assign fp_issue_idx = (s0_ok && slot_class[0] == IFQ_CL_FP) ?
                        rq.alloc_idx[0] : rq.alloc_idx[1];

  always_ff @(posedge clk) begin
    if (reset) begin
      int_done_reg[0] <= 1'b0;
      int_done_reg[1] <= 1'b0;
    end else begin
      int_done_reg[0] <= s0_ok && slot_class[0] != IFQ_CL_FP;
      int_done_reg[1] <= s1_ok && slot_class[1] != IFQ_CL_FP;
    end
    int_idx_reg[0] <= rq.alloc_idx[0];
    int_idx_reg[1] <= rq.alloc_idx[1];
  end

  always_comb begin
    rq.finish_vec = '0;
    if (int_done_reg[0]) rq.finish_vec[int_idx_reg[0]] = 1'b1;
    if (int_done_reg[1]) rq.finish_vec[int_idx_reg[1]] = 1'b1;
    if (fp_done)         rq.finish_vec[fp_done_idx]    = 1'b1;
  end

  ifq_fp_pipe u_fp (
    .clk         (clk),
    .reset       (reset),
    .issue_valid (fp_issue),
    .issue_idx   (fp_issue_idx),
    .done_valid  (fp_done),
    .done_idx    (fp_done_idx)
  );

  ifq_retire_queue u_rq (
    .clk   (clk),
    .reset (reset),
    .rq    (rq)
  );

  assign fetch_slot_first  = iq_reg[0];
  assign fetch_slot_second = iq_reg[1];
  assign retire_count      = rq.retire_count;
  assign iq_level          = iq_cnt_reg;
endmodule
`default_nettype wire

// File: inc/ifq_pkg.sv
// Purpose: shared constants and types for the fetch/dispatch/retire block
// Assumes: single core clock, synchronous active-high reset
// Notes:   instruction words are 32 bits; a memory beat carries two
`default_nettype none
package ifq_pkg;
  localparam int INSN_W       = 32;
  localparam int ADDR_W       = 32;
  localparam int IQ_DEPTH     = 6;
  localparam int IQ_CNT_W     = 3;
  localparam int FETCH_MAX    = 4;
  localparam int DISP_MAX     = 2;
  localparam int RQ_DEPTH     = 6;
  localparam int RQ_IDX_W     = 3;
  localparam int RETIRE_MAX   = 2;
  localparam int FP_STAGES    = 3;
  localparam int BTC_INSNS    = 2;
  localparam int BEAT_INSNS   = 2;
  localparam int L2_LATENCY   = 5;
  localparam int L2_CNT_W     = 3;
  localparam logic [IQ_CNT_W-1:0] IQ_CNT_ZERO = 3'h0;
  localparam logic [ADDR_W-1:0]   RESET_PC    = 32'h0000_0000;
  localparam logic [ADDR_W-1:0]   INSN_BYTES  = 32'h0000_0004;

  typedef logic [INSN_W-1:0] ifq_insn_type;

  // source that answers the current fetch
  typedef enum logic [1:0] {
    IFQ_SRC_L1, IFQ_SRC_BTC, IFQ_SRC_L2, IFQ_SRC_MEM
  } ifq_src_type;

  // fetch engine states
  typedef enum logic [2:0] {
    IFQ_ST_IDLE, IFQ_ST_WAIT_RELOAD, IFQ_ST_L2, IFQ_ST_MEM
  } ifq_state_type;

  // instruction classes known at decode
  typedef enum logic [1:0] {
    IFQ_CL_INT, IFQ_CL_FP, IFQ_CL_BRANCH_FOLD, IFQ_CL_BRANCH_LINK
  } ifq_class_type;
endpackage
`default_nettype wire

// File: inc/ifq_retire_if.sv
// Purpose: carrier between the top and the retire queue
// Assumes: dispatch and finish are same-cycle requests
// Notes:   vacancy is last-cycle free count, used to gate dispatch
`default_nettype none
interface ifq_retire_if;
  import ifq_pkg::*;
  logic [1:0]          alloc_count;
  logic [RQ_IDX_W-1:0] vacancy;
  logic [RQ_IDX_W-1:0] alloc_idx [DISP_MAX];
  logic [RQ_DEPTH-1:0] finish_vec;
  logic [1:0]          retire_count;
  logic                flush;
  modport owner (input alloc_count, finish_vec, flush,
                 output vacancy, alloc_idx, retire_count);
  modport user  (output alloc_count, finish_vec, flush,
                 input vacancy, alloc_idx, retire_count);
endinterface
`default_nettype wire

// File: rtl/ifq_fp_pipe.sv
// Purpose: three-stage floating-point execute pipeline timing model
// Assumes: one issue per cycle, no stalls inside the pipe
// Notes:   carries the retire queue index of each instruction
`default_nettype none
module ifq_fp_pipe
  import ifq_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // issue side
  input  wire logic                issue_valid,
  input  wire logic [RQ_IDX_W-1:0] issue_idx,
  // finish side
  output logic                     done_valid,
  output logic [RQ_IDX_W-1:0]      done_idx
);
  import ifq_pkg::*;
  logic [FP_STAGES-1:0] valid_reg;
  logic [RQ_IDX_W-1:0]  idx_reg [FP_STAGES];

  // each stage advances every cycle so a new op may enter each cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      valid_reg <= '0;
    end else begin
      valid_reg <= {valid_reg[FP_STAGES-2:0], issue_valid}; // see RL10
    end
  end

  always_ff @(posedge clk) begin
    idx_reg[0] <= issue_idx;
  end

  genvar s;
  generate
    for (s = 1; s < FP_STAGES; s++) begin : g_stage
      always_ff @(posedge clk) begin
        idx_reg[s] <= idx_reg[s-1];
      end
    end
  endgenerate

  assign done_valid = valid_reg[FP_STAGES-1];
  assign done_idx   = idx_reg[FP_STAGES-1];
endmodule
`default_nettype wire

// File: rtl/ifq_retire_queue.sv
// Purpose: six-entry in-order retire queue
// Assumes: allocation count never exceeds last-cycle vacancy
// Notes:   up to two oldest finished entries retire per cycle
`default_nettype none
module ifq_retire_queue
  import ifq_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // queue port
  ifq_retire_if.owner rq
);
  import ifq_pkg::*;
  logic [RQ_DEPTH-1:0] busy_reg;
  logic [RQ_DEPTH-1:0] done_reg;
  logic [RQ_IDX_W-1:0] head_reg;
  logic [RQ_IDX_W-1:0] tail_reg;
  logic [RQ_IDX_W-1:0] count_reg;
  logic [RQ_IDX_W-1:0] vacancy_reg;

  function automatic logic [RQ_IDX_W-1:0] wrap_add(
    input logic [RQ_IDX_W-1:0] a, input logic [RQ_IDX_W-1:0] b);
    logic [RQ_IDX_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= RQ_IDX_W'(RQ_DEPTH)) s = s - (RQ_IDX_W+1)'(RQ_DEPTH);
    return s[RQ_IDX_W-1:0];
  endfunction

  // retire only from the head, oldest first, at most two
  wire [RQ_IDX_W-1:0] head1 = wrap_add(head_reg, RQ_IDX_W'(1));
  wire ret0 = busy_reg[head_reg] && (done_reg[head_reg] ||
              rq.finish_vec[head_reg]);                     // see RL11
  wire ret1 = ret0 && busy_reg[head1] && (done_reg[head1] ||
              rq.finish_vec[head1]);                        // see RL12
  wire [1:0] ret_n = {1'b0, ret0} + {1'b0, ret1};

  assign rq.retire_count = ret_n;
  assign rq.vacancy      = vacancy_reg;
  assign rq.alloc_idx[0] = tail_reg;                        // see RL16
  assign rq.alloc_idx[1] = wrap_add(tail_reg, RQ_IDX_W'(1));

  // free entries at end of the retiring cycle; fifo pointers
  always_ff @(posedge clk) begin
    if (reset || rq.flush) begin
      busy_reg    <= '0;
      done_reg    <= '0;
      head_reg    <= '0;
      tail_reg    <= '0;
      count_reg   <= '0;
      vacancy_reg <= RQ_IDX_W'(RQ_DEPTH);
    end else begin
      busy_reg <= busy_reg;
      done_reg <= done_reg | rq.finish_vec;
      if (ret0) begin
        busy_reg[head_reg] <= 1'b0;                         // see RL13
        done_reg[head_reg] <= 1'b0;
      end
      if (ret1) begin
        busy_reg[head1] <= 1'b0;
        done_reg[head1] <= 1'b0;
      end
      if (rq.alloc_count != 2'h0) busy_reg[tail_reg] <= 1'b1;
      if (rq.alloc_count == 2'h2) busy_reg[rq.alloc_idx[1]] <= 1'b1;
      head_reg    <= wrap_add(head_reg, RQ_IDX_W'(ret_n));
      tail_reg    <= wrap_add(tail_reg, RQ_IDX_W'(rq.alloc_count));
      count_reg   <= count_reg + RQ_IDX_W'(rq.alloc_count)
                     - RQ_IDX_W'(ret_n);
      vacancy_reg <= RQ_IDX_W'(RQ_DEPTH) - count_reg
                     - RQ_IDX_W'(rq.alloc_count) + RQ_IDX_W'(ret_n);
    end
  end
endmodule
`default_nettype wire

// File: verification/ifq_front_end_checker.sv
// Purpose: timing checks on the fetch and retire ports
// Assumes: single clock, synchronous active-high reset
// Notes:   observes ports only; bound to the front end below
`default_nettype none
module ifq_front_end_checker
  import ifq_pkg::*;
(
  // clock and reset
  input wire logic                clk,
  input wire logic                reset,
  // fetch side
  input wire logic                l1_req,
  input wire logic [2:0]          l1_count,
  input wire logic                l1_busy,
  input wire logic                l1_hit,
  input wire logic                l2_req,
  input wire logic                l2_hit,
  input wire logic                mem_req,
  input wire logic                mem_beat,
  input wire logic                fill_write,
  // queue side
  input wire logic [1:0]          disp_count,
  input wire logic [1:0]          retire_count,
  input wire logic [IQ_CNT_W-1:0] iq_level
);
  // all checks are muted while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_busy_holds_fetch: assert property (l1_busy |-> !l1_req)
    else $error("fetch during line reload");
  a_miss_stops_fetch: assert property (
    l1_req && !l1_hit |=> !l1_req [*4]) else $error("fetch in miss wait");
  a_mem_blocks_fetch: assert property (mem_req |-> !l1_req)
    else $error("fetch while waiting on memory");
  a_hit_fills_queue: assert property (
    l1_req && l1_hit |=> iq_level != 3'h0) else $error("hit not queued");
  a_fetch_vacancy: assert property (
    l1_req |-> l1_count == ((iq_level > 3'h2) ? 3'h6 - iq_level : 3'h4))
    else $error("fetch count not the vacancy");
  a_queue_bound: assert property (iq_level <= 3'h6)
    else $error("queue over depth");
  a_fill_with_beat: assert property (
    fill_write == (mem_req && mem_beat)) else $error("fill not with beat");
  a_l2_latency: assert property (
    l1_req && !l1_hit |-> ##5 l2_req) else $error("level-two latency");
  a_l2_miss_mem: assert property (
    l2_req && !l2_hit |=> mem_req) else $error("no memory request");
  a_mem_req_holds: assert property (
    mem_req && !mem_beat |=> mem_req) else $error("memory request dropped");
  a_two_retire_max: assert property (retire_count != 2'h3)
    else $error("three retired");
  a_two_disp_max: assert property (disp_count != 2'h3)
    else $error("three dispatched");
  a_reset_empties: assert property (
    $fell(reset) |-> iq_level == 3'h0) else $error("queue kept over reset");
endmodule
bind ifq_front_end ifq_front_end_checker u_chk (
  .clk(clk), .reset(reset), .l1_req(l1_req), .l1_count(l1_count),
  .l1_busy(l1_busy), .l1_hit(l1_hit), .l2_req(l2_req), .l2_hit(l2_hit),
  .mem_req(mem_req), .mem_beat(mem_beat), .fill_write(fill_write),
  .disp_count(disp_count), .retire_count(retire_count),
  .iq_level(iq_level));
`default_nettype wire

// File: verification/ifq_cache_model.sv
// Purpose: behavioural caches and system bus facing the fetch block
// Assumes: the bench steers hits, misses and reloads
// Notes:   idle answers carry a moving junk pattern, never old data
`default_nettype none
module ifq_cache_model
  import ifq_pkg::*;
(
  // clock
  input  wire logic              clk,
  // requests from the fetcher
  input  wire logic              l1_req,
  input  wire logic [ADDR_W-1:0] l1_addr,
  input  wire logic              l2_req,
  input  wire logic              mem_req,
  // bench steering
  input  wire logic              miss_l1,
  input  wire logic              miss_l2,
  input  wire logic              reload,
  input  wire logic              btc_ok,
  // answers
  output logic                   l1_busy,
  output logic                   l1_hit,
  output logic                   btc_hit,
  output logic                   l2_hit,
  output logic                   mem_beat,
  output ifq_insn_type           l1_data [FETCH_MAX],
  output ifq_insn_type           btc_data [BTC_INSNS],
  output ifq_insn_type           l2_data [BEAT_INSNS],
  output ifq_insn_type           mem_data [BEAT_INSNS]
);
  logic [2:0]  wait_reg = 3'h0;
  logic [31:0] junk_reg = 32'h5a5a_1234;
  // bus latency count; junk moves so a stale match cannot pass
  always_ff @(posedge clk) begin
    wait_reg <= mem_req ? wait_reg + 3'h1 : 3'h0;
    junk_reg <= {junk_reg[30:0], ~junk_reg[31]} ^ 32'h0000_0100;
  end
  // level-one answers in the request cycle unless steered to miss
  assign l1_busy  = reload;
  assign l1_hit   = l1_req && !miss_l1;
  assign btc_hit  = btc_ok;
  assign l2_hit   = l2_req && !miss_l2;
  assign mem_beat = mem_req && wait_reg == 3'h3;
  for (genvar i = 0; i < FETCH_MAX; i++) begin : g_l1
    assign l1_data[i] = l1_hit ? l1_addr + 32'(i) : junk_reg;
  end
  // two words per beat, older word first
  for (genvar i = 0; i < BEAT_INSNS; i++) begin : g_beat
    assign btc_data[i] = btc_hit ? 32'h00c0_0000 + 32'(i) : ~junk_reg;
    assign l2_data[i]  = l2_hit ? 32'h00a0_0000 + 32'(i) : junk_reg;
    assign mem_data[i] = mem_beat ? 32'h00b0_0000 + 32'(i) : ~junk_reg;
  end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: random and directed run of the fetch and retire block
// Assumes: classes kept to integer and float outside the fold test
// Notes:   queue level is predicted only while no branch is in flight
`default_nettype none
module tb_top
  import ifq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = 1'h0;
  logic                reset = 1'h1;
  logic                miss_l1 = 1'h0, miss_l2 = 1'h0, br_link = 1'h0;
  logic                reload = 1'h0, btc_ok = 1'h0, br_taken = 1'h0;
  logic [ADDR_W-1:0]   br_target = 32'h0000_0000, l1_addr;
  logic                l1_req, l1_busy, l1_hit, btc_hit, l2_req, l2_hit;
  logic                mem_req, mem_beat, fill_write;
  logic [2:0]          l1_count;
  logic [1:0]          disp_count, retire_count;
  logic [IQ_CNT_W-1:0] iq_level;
  ifq_insn_type        l1_data [FETCH_MAX], btc_data [BTC_INSNS];
  ifq_insn_type        l2_data [BEAT_INSNS], mem_data [BEAT_INSNS];
  ifq_insn_type        fill_data [BEAT_INSNS], slot_first, slot_second;
  ifq_class_type       slot_class [DISP_MAX];
  int                  seed = 79, mismatches = 0, check_count = 0;
  int                  occ = 0, exp_iq = 0, n = 0;
  bit                  have = 1'h0, found;

  initial forever #12.5 clk = ~clk;

  ifq_front_end u_dut (
    .clk(clk), .reset(reset), .l1_req(l1_req), .l1_addr(l1_addr),
    .l1_count(l1_count), .l1_busy(l1_busy), .l1_hit(l1_hit),
    .l1_data(l1_data), .btc_hit(btc_hit), .btc_data(btc_data),
    .l2_req(l2_req), .l2_hit(l2_hit), .l2_data(l2_data),
    .mem_req(mem_req), .mem_beat(mem_beat), .mem_data(mem_data),
    .fill_write(fill_write), .fill_data(fill_data),
    .br_taken(br_taken), .br_target(br_target), .br_updates_link(br_link),
    .slot_class(slot_class), .disp_count(disp_count),
    .fetch_slot_first(slot_first), .fetch_slot_second(slot_second),
    .retire_count(retire_count), .iq_level(iq_level));
  ifq_cache_model u_mem (
    .clk(clk), .l1_req(l1_req), .l1_addr(l1_addr), .l2_req(l2_req),
    .mem_req(mem_req), .miss_l1(miss_l1), .miss_l2(miss_l2),
    .reload(reload), .btc_ok(btc_ok), .l1_busy(l1_busy),
    .l1_hit(l1_hit), .btc_hit(btc_hit), .l2_hit(l2_hit),
    .mem_beat(mem_beat), .l1_data(l1_data), .btc_data(btc_data),
    .l2_data(l2_data), .mem_data(mem_data));

  task automatic check(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s %0h not %0h", $time, what, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // inputs move a fixed 2 ns after the rising edge
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  // bounded wait; running out of cycles ends the run as a failure
  task automatic wait_hi(ref logic s, output int k);
    k = 0;
    while (s !== 1'h1) begin
      step(1);
      k++;
      if (k > 40) begin
        mismatches++;
        summarize();
      end
    end
  endtask

  // queue level and retire occupancy predicted from what crossed ports
  always @(negedge clk) begin
    if (reset) begin
      occ = 0;
      have = 1'h0;
    end else begin
      if (have) check(32'(iq_level), 32'(exp_iq), "level");
      check(32'(disp_count <= RQ_DEPTH - occ), 32'h1, "vacancy");
      check(32'(retire_count <= occ), 32'h1, "early retire");
      exp_iq = iq_level - disp_count + (l1_req && l1_hit ? l1_count : 0)
               + (l2_req && l2_hit ? 2 : 0) + (mem_req && mem_beat ? 2 : 0);
      occ = occ + disp_count - retire_count;
      check(32'(occ <= RQ_DEPTH), 32'h1, "retire depth");
      have = !br_taken && !btc_ok;
    end
  end

  initial begin
    slot_class[0] = IFQ_CL_INT;
    slot_class[1] = IFQ_CL_INT;
    step(3);
    reset = 1'h0;
    #1;
    check(32'(iq_level), 32'h0, "level after reset");
    // random class mix with line reloads sprinkled in
    repeat (300) begin
      step(1);
      slot_class[0] = ifq_class_type'(2'($random(seed) & 1));
      slot_class[1] = ifq_class_type'(2'($random(seed) & 1));
      reload = (($random(seed) & 3) == 0);
    end
    reload = 1'h0;
    slot_class[0] = IFQ_CL_INT;
    slot_class[1] = IFQ_CL_INT;
    $display("test random done");
    // a taken branch that writes the link is dispatched, not folded
    step(6);
    slot_class[0] = IFQ_CL_BRANCH_LINK;
    br_taken = 1'h1;
    br_link = 1'h1;
    #1;
    check(32'(disp_count != 2'h0), 32'h1, "link dispatch");
    // taken branch without link folds; target cache supplies the target
    step(1);
    br_link = 1'h0;
    slot_class[0] = IFQ_CL_BRANCH_FOLD;
    br_target = 32'h0000_0100;
    #1;
    check(32'(disp_count), 32'h0, "folded dispatch");
    step(1);
    br_taken = 1'h0;
    slot_class[0] = IFQ_CL_INT;
    btc_ok = 1'h1;
    step(1);
    btc_ok = 1'h0;
    found = 1'h0;
    #1;
    check(l1_addr, 32'h0000_0108, "redirect address");
    repeat (4) begin
      #1;
      if (slot_first === 32'h00c0_0000 &&
          slot_second === 32'h00c0_0001) found = 1'h1;
      step(1);
    end
    check(32'(found), 32'h1, "target in first slot");
    $display("test fold done");
    // first-level miss served by level two, then by memory
    for (int m = 0; m < 2; m++) begin
      miss_l1 = 1'h1;
      miss_l2 = m[0];
      wait_hi(l1_req, n);
      wait_hi(l2_req, n);
      check(32'(n), 32'h5, "level-two wait");
      miss_l1 = 1'h0;
      if (m == 1) begin
        step(1);
        check(32'(mem_req), 32'h1, "memory request");
        wait_hi(mem_beat, n);
        check(32'(fill_write), 32'h1, "fill strobe");
        check(fill_data[0], 32'h00b0_0000, "fill word 0");
        check(fill_data[1], 32'h00b0_0001, "fill word 1");
        miss_l2 = 1'h0;
      end
      step(10);
    end
    $display("test miss done");
    // reset in mid-run empties both queues
    reset = 1'h1;
    step(3);
    reset = 1'h0;
    #1;
    check(32'(iq_level), 32'h0, "level after reset");
    check(32'(retire_count), 32'h0, "retire after reset");
    step(30);
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire
